// file: logic/iret_pkg.sv
// Package with register map, field layout and constants of the IR envelope timer block.
package iret_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FRONT_END_ADDR = 8'h11;
  localparam logic [7:0] TIMER_CTRL_ADDR = 8'h22;
  localparam logic [7:0] COUNT_LOW_ADDR = 8'h25;
  localparam logic [7:0] COUNT_HIGH_ADDR = 8'h26;
  localparam logic [7:0] STATUS_ADDR = 8'h27;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT = 7;
  localparam int TICK_SEL_LSB = 4;
  localparam int DRIVE_LSB = 3;
  localparam int CAPSEL_BIT = 2;
  localparam int SENSE_LSB = 0;
  localparam int WRAP_FLAG_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FRONT_END_RESET = 8'h00;
  localparam logic [11:0] COUNT_RESET = 12'h000;
  localparam logic [11:0] COUNT_MAX = 12'hFFF;
  localparam logic [5:0] DIV4_LAST = 6'h03;
  localparam logic [5:0] DIV64_LAST = 6'h3F;

  // ----------------------------------------------------------------
  // Tick source encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] TICK_OSC = 2'h0;
  localparam logic [1:0] TICK_DIV4 = 2'h1;
  localparam logic [1:0] TICK_DIV64 = 2'h2;
  localparam logic [1:0] TICK_CARRIER = 2'h3;

endpackage

// file: logic/iret_top.sv
// Envelope timer with IR front-end control, single clock domain.
//
// Overview of operation
// - A 12-bit counter steps by one on each selected tick while enabled.
// - Control bits 5:4 choose the oscillator, divide by 4, divide by 64 or the carrier tick.
// - On overflow the counter reloads from the preset low byte and high nibble.
// - The wrap flag rises each time the counter passes from 0xFFF to the preset reload value.
// - Control bit 7 enables counting and resets to 0.
// - Reading the low count register gives live counter bits 7:0, writing sets the preset low byte.
// - The high count register reads counter bits 11:8 and writes the preset high nibble; 7:4 reserved.
// - Front-end bits 4:3 select quarter, half, three-quarter or full LED drive current.
// - In the reduced variant only bit 3 selects drive strength, giving drive field 00 or 01.
// - Front-end bit 2 takes the capture input from the receiver when 0, port C bit 3 when 1.
// - Front-end bits 1:0 set receiver sensitivity from most (00) to least (11).
// - Drive and sensitivity/capture fields share one write-only address updated together.
// - The digitised receiver output feeds the carrier timer capture input while front-end bit 2 is 0.
// - The LED is switched by the carrier PWM, and envelope output combines both timers.
`timescale 1ns/1ps
`default_nettype none

module iret_top #(
  parameter bit REDUCED_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic carrier_tick,
  input wire logic carrier_pwm_out,
  input wire logic rx_digital_out,
  input wire logic port_c_bit3,
  output logic capture_in,
  output logic led_drive_on,
  output logic envelope_pwm_out,
  output logic [1:0] led_drive_strength,
  output logic [1:0] rx_sensitivity,
  output logic envelope_wrap_flag,
  output logic envelope_wrap_pulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic envelope_timer_on;
    logic [1:0] tick_source_sel;
    logic [7:0] preset_low_byte;
    logic [3:0] preset_high_nibble;
    logic [11:0] count;
    logic [5:0] prescale;
    logic carrier_prev;
    logic [1:0] led_drive_field;
    logic capture_input_sel;
    logic [1:0] rx_sensitivity;
    logic wrap_flag;
    logic wrap_pulse;
    logic env_gate;
    logic [7:0] rdata;
    logic capture_in;
    logic led_drive_on;
    logic envelope_pwm_out;
  } iret_state_t;

  iret_state_t state_ff;
  iret_state_t nxt_state;

  localparam iret_state_t STATE_RESET = '{
    envelope_timer_on: iret_pkg::CTRL_RESET[iret_pkg::ENABLE_BIT],
    tick_source_sel: iret_pkg::TICK_OSC,
    preset_low_byte: iret_pkg::COUNT_RESET[7:0],
    preset_high_nibble: iret_pkg::COUNT_RESET[11:8],
    count: iret_pkg::COUNT_RESET,
    prescale: 6'h00,
    carrier_prev: 1'b0,
    led_drive_field: iret_pkg::FRONT_END_RESET[4:3],
    capture_input_sel: iret_pkg::FRONT_END_RESET[iret_pkg::CAPSEL_BIT],
    rx_sensitivity: iret_pkg::FRONT_END_RESET[1:0],
    wrap_flag: 1'b0,
    wrap_pulse: 1'b0,
    env_gate: 1'b0,
    rdata: 8'h00,
    capture_in: 1'b0,
    led_drive_on: 1'b0,
    envelope_pwm_out: 1'b0
  };

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic tick;
  logic carrier_rise;
  logic wrap;
  logic [7:0] rd_value;

  always_comb begin
    nxt_state = state_ff;
    carrier_rise = carrier_tick & ~state_ff.carrier_prev;
    nxt_state.carrier_prev = carrier_tick;

    // Prescaler free-runs so that divided ticks keep a steady rhythm.
    nxt_state.prescale = state_ff.prescale + 6'h01;
    case (state_ff.tick_source_sel)
      iret_pkg::TICK_OSC: tick = 1'b1;
      iret_pkg::TICK_DIV4: tick = (state_ff.prescale[1:0] == iret_pkg::DIV4_LAST[1:0]);
      iret_pkg::TICK_DIV64: tick = (state_ff.prescale == iret_pkg::DIV64_LAST);
      iret_pkg::TICK_CARRIER: tick = carrier_rise;
      default: tick = 1'b0;
    endcase

    wrap = 1'b0;
    if (state_ff.envelope_timer_on && tick) begin
      if (state_ff.count == iret_pkg::COUNT_MAX) begin
        wrap = 1'b1;
        nxt_state.count = {state_ff.preset_high_nibble, state_ff.preset_low_byte};
      end else begin
        nxt_state.count = state_ff.count + 12'h001;
      end
    end
    nxt_state.wrap_pulse = wrap;
    if (wrap) begin
      nxt_state.env_gate = ~state_ff.env_gate;
    end

    // Register reads, data valid in the following cycle.
    rd_value = 8'h00;
    if (addr_hit(reg_addr, iret_pkg::TIMER_CTRL_ADDR)) begin
      rd_value = {state_ff.envelope_timer_on, 1'b0, state_ff.tick_source_sel, 4'h0};
    end else if (addr_hit(reg_addr, iret_pkg::COUNT_LOW_ADDR)) begin
      rd_value = state_ff.count[7:0];
    end else if (addr_hit(reg_addr, iret_pkg::COUNT_HIGH_ADDR)) begin
      rd_value = {4'h0, state_ff.count[11:8]};
    end else if (addr_hit(reg_addr, iret_pkg::STATUS_ADDR)) begin
      rd_value = {7'h00, state_ff.wrap_flag};
    end
    nxt_state.rdata = reg_rd ? rd_value : 8'h00;

    // Wrap flag clears on a status read; a simultaneous wrap wins.
    if (reg_rd && addr_hit(reg_addr, iret_pkg::STATUS_ADDR)) begin
      nxt_state.wrap_flag = 1'b0;
    end
    if (wrap) begin
      nxt_state.wrap_flag = 1'b1;
    end

    if (reg_wr) begin
      if (addr_hit(reg_addr, iret_pkg::TIMER_CTRL_ADDR)) begin
        nxt_state.envelope_timer_on = reg_wdata[iret_pkg::ENABLE_BIT];
        nxt_state.tick_source_sel = reg_wdata[iret_pkg::TICK_SEL_LSB +: 2];
      end
      if (addr_hit(reg_addr, iret_pkg::COUNT_LOW_ADDR)) begin
        nxt_state.preset_low_byte = reg_wdata;
      end
      if (addr_hit(reg_addr, iret_pkg::COUNT_HIGH_ADDR)) begin
        nxt_state.preset_high_nibble = reg_wdata[3:0];
      end
      if (addr_hit(reg_addr, iret_pkg::FRONT_END_ADDR)) begin
        // All front-end fields update from one write.
        if (REDUCED_VARIANT) begin
          nxt_state.led_drive_field = {1'b0, reg_wdata[iret_pkg::DRIVE_LSB]};
        end else begin
          nxt_state.led_drive_field = reg_wdata[iret_pkg::DRIVE_LSB +: 2];
        end
        nxt_state.capture_input_sel = reg_wdata[iret_pkg::CAPSEL_BIT];
        nxt_state.rx_sensitivity = reg_wdata[iret_pkg::SENSE_LSB +: 2];
      end
    end

    // Front-end routing, registered so every output leaves a flip-flop.
    nxt_state.capture_in = state_ff.capture_input_sel ? port_c_bit3 : rx_digital_out;
    nxt_state.led_drive_on = carrier_pwm_out;
    nxt_state.envelope_pwm_out = carrier_pwm_out & state_ff.env_gate;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= STATE_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata = state_ff.rdata;
  assign capture_in = state_ff.capture_in;
  assign led_drive_on = state_ff.led_drive_on;
  assign envelope_pwm_out = state_ff.envelope_pwm_out;
  assign led_drive_strength = state_ff.led_drive_field;
  assign rx_sensitivity = state_ff.rx_sensitivity;
  assign envelope_wrap_flag = state_ff.wrap_flag;
  assign envelope_wrap_pulse = state_ff.wrap_pulse;

endmodule // iret_top

`default_nettype wire

// file: bench/iret_assertions.sv
// Concurrent checks on the ports of the envelope timer block.
`timescale 1ns/1ps
`default_nettype none
module iret_assertions #(
  parameter bit REDUCED = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic carrier_pwm_out,
  input wire logic led_drive_on,
  input wire logic envelope_pwm_out,
  input wire logic [1:0] led_drive_strength,
  input wire logic [1:0] rx_sensitivity,
  input wire logic envelope_wrap_flag,
  input wire logic envelope_wrap_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_front_wo: assert property ($past(reg_rd) && $past(reg_addr) == 8'h11 |-> reg_rdata == 8'h00)
    else $error("front-end address readable");
  a_high_rsvd: assert property ($past(reg_rd) && $past(reg_addr) == 8'h26 |-> reg_rdata[7:4] == 4'h0)
    else $error("high count reserved bits set");
  a_ctrl_rsvd: assert property ($past(reg_rd) && $past(reg_addr) == 8'h22
    |-> reg_rdata[6] == 1'b0 && reg_rdata[3:0] == 4'h0)
    else $error("control reserved bits set");
  a_drive_load: assert property (reg_wr && reg_addr == 8'h11 |=> led_drive_strength ==
    (REDUCED ? {1'b0, $past(reg_wdata[3])} : $past(reg_wdata[4:3])))
    else $error("drive field not loaded");
  a_sense_load: assert property (reg_wr && reg_addr == 8'h11 |=> rx_sensitivity == $past(reg_wdata[1:0]))
    else $error("sense field not loaded");
  a_led_follow: assert property (led_drive_on == $past(carrier_pwm_out))
    else $error("led drive not following carrier");
  a_env_gate: assert property (envelope_pwm_out |-> led_drive_on)
    else $error("envelope output without carrier");
  a_wrap_flag: assert property (envelope_wrap_pulse |-> envelope_wrap_flag)
    else $error("wrap pulse without flag");
endmodule // iret_assertions
bind iret_top iret_assertions #(.REDUCED(REDUCED_VARIANT)) i_chk (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .carrier_pwm_out(carrier_pwm_out), .led_drive_on(led_drive_on),
  .envelope_pwm_out(envelope_pwm_out), .led_drive_strength(led_drive_strength),
  .rx_sensitivity(rx_sensitivity), .envelope_wrap_flag(envelope_wrap_flag),
  .envelope_wrap_pulse(envelope_wrap_pulse));
`default_nettype wire

// file: bench/iret_front_end_model.sv
// Far-side model: carrier timer outputs, receiver output and port pin.
`timescale 1ns/1ps
`default_nettype none
module iret_front_end_model (
  input wire logic clk,
  input wire logic rst_b,
  output logic carrier_tick,
  output logic carrier_pwm_out,
  output logic rx_digital_out,
  output logic port_c_bit3
);
  logic [2:0] cnt_ff = 3'h0;
  // The carrier tick rises once every 8 clocks; PWM toggles every 2 clocks, receiver output every clock, port pin is tick XOR receiver.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 3'h0;
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
    end
  end
  assign carrier_tick = cnt_ff[2];
  assign carrier_pwm_out = cnt_ff[1];
  assign rx_digital_out = cnt_ff[0];
  assign port_c_bit3 = cnt_ff[2] ^ cnt_ff[0];
endmodule // iret_front_end_model
`default_nettype wire

// file: bench/iret_top_test.sv
// Self-checking testbench of the envelope timer block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, e); end end
module iret_top_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, q;
  logic tick, pwm, rx, pc, cap, led, r0, p0, w0, flag, pulse;
  logic [1:0] drv, sen, drv_lite;
  int bad_count = 0;
  int samples_checked = 0;
  int n;
  int dv [4] = '{1, 4, 64, 8};
  always #12.5 clk = ~clk;
  iret_top i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .carrier_tick(tick),
    .carrier_pwm_out(pwm), .rx_digital_out(rx), .port_c_bit3(pc), .capture_in(cap),
    .led_drive_on(led), .envelope_pwm_out(), .led_drive_strength(drv),
    .rx_sensitivity(sen), .envelope_wrap_flag(flag), .envelope_wrap_pulse(pulse));
  // Reduced variant shares the bus; only its drive field is compared.
  iret_top #(.REDUCED_VARIANT(1'b1)) i_dut_lite (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .carrier_tick(tick),
    .carrier_pwm_out(pwm), .rx_digital_out(rx), .port_c_bit3(pc), .capture_in(),
    .led_drive_on(), .envelope_pwm_out(), .led_drive_strength(drv_lite),
    .rx_sensitivity(), .envelope_wrap_flag(), .envelope_wrap_pulse());
  iret_front_end_model i_far (.clk(clk), .rst_b(rst_b), .carrier_tick(tick),
    .carrier_pwm_out(pwm), .rx_digital_out(rx), .port_c_bit3(pc));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
    `CHK(q, e)
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic waitp(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (pulse !== 1'b1 && k < 9000);
    if (k >= 9000) begin
      bad_count++;
      tally_and_finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    chk_rd(8'h22, 8'h00);
    chk_rd(8'h26, 8'h00);
    chk_rd(8'h11, 8'h00);
    chk_rd(8'h3A, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(8'h11, {3'h7, i[1:0], i[2], ~i[1:0]});
      @(negedge clk);
      `CHK(drv, i[1:0])
      `CHK(drv_lite, {1'b0, i[0]})
      `CHK(sen, ~i[1:0])
      repeat (3) begin
        r0 = rx;
        p0 = pc;
        w0 = pwm;
        @(negedge clk);
        `CHK(cap, i[2] ? p0 : r0)
        `CHK(led, w0)
      end
    end
    wr(8'h25, 8'hFC);
    wr(8'h26, 8'hFF);
    wr(8'h22, 8'hCF);
    chk_rd(8'h22, 8'h80);
    waitp(n);
    // Each wrap reloads 0xFFC, so four ticks of the chosen source lie between wraps.
    for (int s = 0; s < 4; s++) begin
      wr(8'h22, 8'h80 | 8'(s << 4));
      waitp(n);
      waitp(n);
      `CHK(n, 4 * dv[s])
    end
    wr(8'h22, 8'h00);
    chk_rd(8'h26, 8'h0F);
    chk_rd(8'h25, 8'hFC);
    chk_rd(8'h25, q);
    chk_rd(8'h27, 8'h01);
    chk_rd(8'h27, 8'h00);
    repeat (20) @(negedge clk);
    `CHK(flag, 1'b0)
    tally_and_finish;
  end
endmodule // iret_top_test
`default_nettype wire
